// >>> ctp_map.vh
// constants for the cascaded 16-bit timer / pwm block
// Functional notes
// - timer mode joins byte counters into one 16-bit up-counter on ticks
// - on compare match raise match interrupt, clear counter, keep counting
// - run bit one starts counting, clearing bit 3 stops the timer
// - compare unbuffered in timer and event modes, a write acts at once
// - main/2^11, 2^7, 2^5, 2^3 ticks; select bit or low speed: sub/2^3
// - event mode counter advances on each falling edge of event input
// - after match clears it, event counter resumes on next falling edge
// - pwm: flip-flop toggles at duty; overflow toggles, clears, interrupts
// - reset clears flip-flop, init bit presets it, pwm pin is its inverse
// - duty buffered: loads at overflow if running, at once if stopped
// - reading duty during pwm returns the buffered value in use
// - stopping holds pin level; init bit changed only in a later write
// - pwm adds sub clock, main/2 and main clock; low speed allows sub only
`ifndef CTP_MAP_VH
`define CTP_MAP_VH
`define CTP_ADDR_LOW_CTRL      4'h0
`define CTP_ADDR_HIGH_CTRL     4'h1
`define CTP_ADDR_CMP_LOW       4'h2
`define CTP_ADDR_CMP_HIGH      4'h3
`define CTP_ADDR_DUTY_LOW      4'h4
`define CTP_ADDR_DUTY_HIGH     4'h5
`define CTP_ADDR_COUNT_LOW     4'h6
`define CTP_ADDR_COUNT_HIGH    4'h7
`define CTP_ADDR_STATUS        4'h8
// lower control: [6:4] clock select, [2:0] mode
`define CTP_LC_CLK_HI          6
`define CTP_LC_CLK_LO          4
`define CTP_LC_MODE_HI         2
`define CTP_LC_MODE_LO         0
// upper control: [7] init bit, [3] run bit, [0] prescaler select
`define CTP_HC_INIT_BIT        7
`define CTP_HC_RUN_BIT         3
`define CTP_HC_PSEL_BIT        0
`define CTP_MODE_TIMER         3'h1
`define CTP_MODE_EVENT         3'h2
`define CTP_MODE_PWM           3'h3
`define CTP_CLK_DIV11          3'h0
`define CTP_CLK_DIV7           3'h1
`define CTP_CLK_DIV5           3'h2
`define CTP_CLK_DIV3           3'h3
`define CTP_CLK_SUB            3'h4
`define CTP_CLK_DIV1           3'h5
`define CTP_CLK_MAIN           3'h6
`define CTP_RST_BYTE           8'h00
`define CTP_RST_WORD           16'h0000
`endif

// >>> ctp_sync.v
// two-flop synchroniser for one pin level
module ctp_sync (
  input  wire clk,
  input  wire rst_n,
  input  wire din,
  output reg  dout
);
  reg meta_q;

  // first stage read only by the second
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= 1'b1;
      dout   <= 1'b1;
    end
    else
    begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule

// >>> ctp_tick.v
// source clock tick selection from the prescaler taps
`include "ctp_map.vh"
module ctp_tick (
  input  wire       clk,
  input  wire       rst_n,
  input  wire [2:0] sel,
  input  wire       psel,
  input  wire       low_speed,
  input  wire       pwm_mode,
  input  wire [3:0] div_taps,
  input  wire       sub_tick,
  input  wire       sub_div3_tick,
  output reg        tick
);
  reg tick_d;
  reg half_q;

  // main/2 made here: a main/8 tap would run four times too slow
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      half_q <= 1'b0;
    else
      half_q <= !half_q;
  end

  // pick one tick source per cycle
  always @*
  begin
    tick_d = 1'b0;
    case (sel)
      `CTP_CLK_DIV11:
        tick_d = (psel | low_speed) ? sub_div3_tick : div_taps[3];
      `CTP_CLK_DIV7:  tick_d = !low_speed & div_taps[2];
      `CTP_CLK_DIV5:  tick_d = !low_speed & div_taps[1];
      `CTP_CLK_DIV3:  tick_d = !low_speed & div_taps[0];
      // extra pwm sources; low speed leaves only sub clock
      `CTP_CLK_SUB:   tick_d = pwm_mode & sub_tick;
      `CTP_CLK_DIV1:  tick_d = pwm_mode & !low_speed & half_q;
      `CTP_CLK_MAIN:  tick_d = pwm_mode & !low_speed;
      default:        tick_d = 1'b0;
    endcase
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      tick <= 1'b0;
    else
      tick <= tick_d;
  end
endmodule

// >>> ctp_timer.v
// cascaded 16-bit timer, event counter and pwm unit
//
// Decided for this implementation: the register addresses and strobed register access.
`include "ctp_map.vh"
module ctp_timer (
  input  wire       mclk,
  input  wire       reset_n,
  input  wire [3:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  input  wire [3:0] div_taps,
  input  wire       sub_tick,
  input  wire       sub_div3_tick,
  input  wire       low_speed,
  input  wire       event_input_pin,
  output reg        match_interrupt,
  output reg        modulated_output_pin
);
  reg        rst_meta_q;
  reg        rst_sync_q;
  wire       rst_n;
  reg  [7:0] lower_timer_control_q;
  reg  [7:0] upper_timer_control_q;
  reg  [7:0] compare_low_byte_q;
  reg  [7:0] compare_high_byte_q;
  reg  [7:0] duty_low_byte_q;
  reg  [7:0] duty_high_byte_q;
  reg  [15:0] duty_active_q;
  reg        duty_pending_q;
  reg  [7:0] count_low_q;
  reg  [7:0] count_high_q;
  reg        tff_q;
  reg        evt_prev_q;
  reg        match_seen_q;
  wire       evt_level;
  wire       tick;
  wire [2:0] mode;
  wire       run;
  wire       is_pwm;
  wire       advance;
  wire [15:0] count;
  wire [15:0] compare;
  wire       at_compare;
  wire       at_duty;
  wire       at_top;
  wire       wrap;
  wire       low_carry;
  wire       wr_init;

  // reset released through two flops
  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end
  assign rst_n = rst_sync_q;

  // event pin comes from outside the clock domain
  ctp_sync u_evt_sync (
    .clk  (mclk),
    .rst_n(rst_n),
    .din  (event_input_pin),
    .dout (evt_level)
  );

  assign mode   = lower_timer_control_q[`CTP_LC_MODE_HI:`CTP_LC_MODE_LO];
  assign run    = upper_timer_control_q[`CTP_HC_RUN_BIT];
  assign is_pwm = (mode == `CTP_MODE_PWM);

  ctp_tick u_tick (
    .clk          (mclk),
    .rst_n        (rst_n),
    .sel          (lower_timer_control_q[`CTP_LC_CLK_HI:`CTP_LC_CLK_LO]),
    .psel         (upper_timer_control_q[`CTP_HC_PSEL_BIT]),
    .low_speed    (low_speed),
    .pwm_mode     (is_pwm),
    .div_taps     (div_taps),
    .sub_tick     (sub_tick),
    .sub_div3_tick(sub_div3_tick),
    .tick         (tick)
  );

  // counting events: prescaled tick or falling edge of the event pin
  assign advance = run & (((mode == `CTP_MODE_TIMER) & tick) |
                          (is_pwm & tick) |
                          ((mode == `CTP_MODE_EVENT) &
                           evt_prev_q & !evt_level));

  assign count      = {count_high_q, count_low_q};
  // compare read straight from the byte registers: no buffer
  assign compare    = {compare_high_byte_q, compare_low_byte_q};
  assign at_compare = (count == compare);
  assign at_duty    = (count == duty_active_q);
  assign at_top     = (count == 16'hffff);
  // timer/event clear on compare, pwm clears on overflow
  assign wrap       = advance & (is_pwm ? at_top : at_compare);
  assign low_carry  = (count_low_q == 8'hff);
  assign wr_init    = reg_wr & (reg_addr == `CTP_ADDR_HIGH_CTRL);

  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      evt_prev_q <= 1'b1;
    else
      evt_prev_q <= evt_level;
  end

  // cascaded counter: low byte carries into high byte
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_low_q  <= `CTP_RST_BYTE;
      count_high_q <= `CTP_RST_BYTE;
    end
    else if (wrap)
    begin
      // cleared, next advance resumes counting
      count_low_q  <= `CTP_RST_BYTE;
      count_high_q <= `CTP_RST_BYTE;
    end
    else if (advance)
    begin
      count_low_q <= count_low_q + 8'h01;
      if (low_carry)
        count_high_q <= count_high_q + 8'h01;
    end
  end

  // match interrupt: one-cycle pulse
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      match_interrupt <= 1'b0;
    else
      match_interrupt <= wrap;
  end

  // output flip-flop; init bit write only presets it when stopped
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      tff_q <= 1'b0;
    else if (wr_init & !run & !reg_wdata[`CTP_HC_RUN_BIT])
      tff_q <= reg_wdata[`CTP_HC_INIT_BIT];
    else if (is_pwm & advance & (at_duty ^ at_top))
      tff_q <= !tff_q;
  end

  // pin is the inverse of the flip-flop; stopped timer holds it
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      modulated_output_pin <= 1'b1;
    else
      modulated_output_pin <= !tff_q;
  end

  // control and compare registers
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lower_timer_control_q <= `CTP_RST_BYTE;
      upper_timer_control_q <= `CTP_RST_BYTE;
      compare_low_byte_q    <= `CTP_RST_BYTE;
      compare_high_byte_q   <= `CTP_RST_BYTE;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `CTP_ADDR_LOW_CTRL:  lower_timer_control_q <= reg_wdata;
        `CTP_ADDR_HIGH_CTRL: upper_timer_control_q <= reg_wdata;
        `CTP_ADDR_CMP_LOW:   compare_low_byte_q    <= reg_wdata;
        `CTP_ADDR_CMP_HIGH:  compare_high_byte_q   <= reg_wdata;
        default:             lower_timer_control_q <= lower_timer_control_q;
      endcase
    end
  end

  // duty write side; bytes held apart until the shift
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      duty_low_byte_q  <= `CTP_RST_BYTE;
      duty_high_byte_q <= `CTP_RST_BYTE;
    end
    else if (reg_wr & (reg_addr == `CTP_ADDR_DUTY_LOW))
      duty_low_byte_q <= reg_wdata;
    else if (reg_wr & (reg_addr == `CTP_ADDR_DUTY_HIGH))
      duty_high_byte_q <= reg_wdata;
  end

  // shift into the active buffer: immediately when stopped or not in pwm mode, else on wrap
  // a write in the wrap cycle stays pending, so no torn value is shifted
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      duty_active_q  <= `CTP_RST_WORD;
      duty_pending_q <= 1'b0;
    end
    else if (reg_wr & (reg_addr == `CTP_ADDR_DUTY_HIGH))
    begin
      if (!run | !is_pwm)
      begin
        duty_active_q  <= {reg_wdata, duty_low_byte_q};
        duty_pending_q <= 1'b0;
      end
      else
        duty_pending_q <= 1'b1;
    end
    else if (duty_pending_q & (wrap | !run))
    begin
      duty_active_q  <= {duty_high_byte_q, duty_low_byte_q};
      duty_pending_q <= 1'b0;
    end
  end

  // sticky match status, set wins over read clear
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      match_seen_q <= 1'b0;
    else if (wrap)
      match_seen_q <= 1'b1;
    else if (reg_rd & (reg_addr == `CTP_ADDR_STATUS))
      match_seen_q <= 1'b0;
  end

  // read data one cycle after the strobe; unmapped reads zero
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= `CTP_RST_BYTE;
    else if (reg_rd)
    begin
      case (reg_addr)
        `CTP_ADDR_LOW_CTRL:   reg_rdata <= lower_timer_control_q;
        `CTP_ADDR_HIGH_CTRL:  reg_rdata <= upper_timer_control_q;
        `CTP_ADDR_CMP_LOW:    reg_rdata <= compare_low_byte_q;
        `CTP_ADDR_CMP_HIGH:   reg_rdata <= compare_high_byte_q;
        `CTP_ADDR_DUTY_LOW:   reg_rdata <= duty_active_q[7:0];
        `CTP_ADDR_DUTY_HIGH:  reg_rdata <= duty_active_q[15:8];
        `CTP_ADDR_COUNT_LOW:  reg_rdata <= count_low_q;
        `CTP_ADDR_COUNT_HIGH: reg_rdata <= count_high_q;
        `CTP_ADDR_STATUS:     reg_rdata <= {6'h00, tff_q, match_seen_q};
        default:              reg_rdata <= `CTP_RST_BYTE;
      endcase
    end
    else
      reg_rdata <= `CTP_RST_BYTE;
  end
endmodule

// >>> ctp_timer_chk.sv
// port-level assertions for the cascaded timer block
module ctp_timer_chk (
  input wire       mclk,
  input wire       reset_n,
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_rdata,
  input wire       match_interrupt,
  input wire       modulated_output_pin
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  // stop write, then a quiet spell long enough to drain the pipeline
  sequence s_stop;
    (reg_wr && reg_addr == 4'h1 && !reg_wdata[3]) ##1 (!reg_wr)[*6];
  endsequence

  // read port and reset state
  a_rdata_idle: assert property
    (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its slot");
  a_unmapped_read: assert property
    (reg_rd && reg_addr > 4'h8 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_pin_reset: assert property
    ($rose(reset_n) |-> modulated_output_pin)
    else $error("pin not high out of reset");
  a_quiet_reset: assert property
    ($rose(reset_n) |-> (!match_interrupt)[*3])
    else $error("interrupt before run");
  // interrupt shape and stopped behaviour
  a_irq_pulse: assert property
    (match_interrupt |=> !match_interrupt)
    else $error("interrupt longer than one cycle");
  a_stop_no_irq: assert property (s_stop |-> !match_interrupt)
    else $error("interrupt while stopped");
  a_stop_pin_hold: assert property
    (s_stop |-> $stable(modulated_output_pin))
    else $error("pin moved while stopped");
  a_init_preset: assert property
    ((reg_wr && reg_addr == 4'h1 && !reg_wdata[3])
    ##1 (!reg_wr)[*3] ##1 (reg_wr && reg_addr == 4'h1 && reg_wdata == 8'h80)
    |-> ##[2:3] !modulated_output_pin)
    else $error("init bit did not preset pin");

  c_irq: cover property (match_interrupt);
  c_pin_fall: cover property ($fell(modulated_output_pin));
  c_unmapped: cover property (reg_rd && reg_addr > 4'h8);
endmodule

// >>> ctp_src_model.sv
// prescaler taps, sub clock ticks and event pin source
module ctp_src_model (
  input  wire logic       mclk,
  input  wire logic       ev_req,
  output logic      [3:0] div_taps,
  output logic            sub_tick,
  output logic            sub_div3_tick,
  output logic            event_input_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [10:0] c_q = 11'h000;
  logic [4:0]  s_q = 5'h00;
  logic [3:0]  e_q = 4'h0;

  initial
  begin
    div_taps = 4'h0;
    sub_tick = 1'b0;
    sub_div3_tick = 1'b0;
    event_input_pin = 1'b1;
  end

  // one-cycle taps; sub ticks kept slow so the periods differ
  always @(posedge mclk)
  begin
    c_q <= c_q + 11'h001;
    s_q <= (s_q == 5'h13) ? 5'h00 : s_q + 5'h01;
    div_taps <= {c_q == 11'h7ff, c_q[6:0] == 7'h7f,
                 c_q[4:0] == 5'h1f, c_q[2:0] == 3'h7};
    sub_tick <= (s_q[1:0] == 2'h0);
    sub_div3_tick <= (s_q == 5'h13);
    e_q <= ev_req ? 4'h8 : ((e_q != 4'h0) ? e_q - 4'h1 : 4'h0);
    event_input_pin <= !(e_q > 4'h4);
  end
endmodule

// >>> testbench.sv
// self-checking bench for the cascaded timer block
`define TB_CHK(act, exp) \
  begin total_checks++; if ((act) !== (exp)) begin num_errors++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, act, exp); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic       mclk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0;
  logic       low_speed = 0, ev_req = 0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, d;
  wire  [7:0] reg_rdata;
  wire  [3:0] div_taps;
  wire        sub_tick, sub_div3_tick, event_input_pin;
  wire        match_interrupt, modulated_output_pin;
  int         num_errors = 0, total_checks = 0, n;
  logic [7:0] lc_t[6] = '{8'h31, 8'h21, 8'h11, 8'h01, 8'h01, 8'h01};
  logic [7:0] hc_t[6] = '{8'h08, 8'h08, 8'h08, 8'h08, 8'h09, 8'h08};
  logic       ls_t[6] = '{0, 0, 0, 0, 0, 1};
  int         per_t[6] = '{32, 128, 512, 8192, 80, 80};

  always #2 mclk = ~mclk;

  ctp_src_model src_u (.mclk(mclk), .ev_req(ev_req), .div_taps(div_taps),
    .sub_tick(sub_tick), .sub_div3_tick(sub_div3_tick),
    .event_input_pin(event_input_pin));
  ctp_timer dut_u (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .div_taps(div_taps), .sub_tick(sub_tick),
    .sub_div3_tick(sub_div3_tick), .low_speed(low_speed),
    .event_input_pin(event_input_pin), .match_interrupt(match_interrupt),
    .modulated_output_pin(modulated_output_pin));

  // bus cycles: one strobe cycle each, data the cycle after a read
  task wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge mclk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, v};
    @(posedge mclk) reg_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a);
    @(posedge mclk) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge mclk) reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task chk_rd(input logic [3:0] a, input logic [7:0] e);
    rd(a);
    `TB_CHK(d, e)
  endtask
  task wt(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task ev_fall;
    @(posedge mclk) ev_req <= 1'b1;
    @(posedge mclk) ev_req <= 1'b0;
    wt(12);
  endtask
  // bounded wait for the interrupt; returns cycles waited in this call
  task wirq(output int k);
    k = 0;
    do
    begin
      @(posedge mclk);
      #1 k++;
    end while (match_interrupt !== 1'b1 && k < 70000);
    if (k >= 70000)
    begin
      num_errors++;
      stop_test();
    end
  endtask
  task stop_test;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // reset, event counter, timer sources, then pwm
  initial
  begin
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (3) @(posedge mclk);
    for (int a = 0; a < 9; a++)
      chk_rd(a[3:0], 8'h00);
    chk_rd(4'hf, 8'h00);
    wr(4'h0, 8'h02);
    wr(4'h2, 8'h05);
    wr(4'h3, 8'h00);
    wr(4'h1, 8'h08);
    repeat (3) ev_fall();
    chk_rd(4'h6, 8'h03);
    chk_rd(4'h7, 8'h00);
    repeat (3) ev_fall();
    chk_rd(4'h8, 8'h01);
    ev_fall();
    chk_rd(4'h6, 8'h01);
    wr(4'h1, 8'h00);
    wr(4'h3, 8'h00);
    wr(4'h2, 8'h03);
    for (int i = 0; i < 6; i++)
    begin
      wr(4'h1, 8'h00);
      low_speed <= ls_t[i];
      wr(4'h0, lc_t[i]);
      wr(4'h1, hc_t[i]);
      wirq(n);
      wirq(n);
      `TB_CHK(n, per_t[i])
    end
    low_speed <= 1'b0;
    chk_rd(4'h8, 8'h01);
    chk_rd(4'h8, 8'h00);
    wr(4'h1, 8'h00);
    // port latch of the pin lies outside the block, taken as set to one
    wr(4'h0, 8'h63);
    wr(4'h4, 8'h10);
    wr(4'h5, 8'h00);
    chk_rd(4'h4, 8'h10);
    wr(4'h1, 8'h08);
    wr(4'h4, 8'h20);
    wr(4'h5, 8'h00);
    chk_rd(4'h4, 8'h10);
    wt(40);
    `TB_CHK(modulated_output_pin, 1'b0)
    wirq(n);
    wr(4'h4, 8'h40);
    wr(4'h5, 8'h00);
    chk_rd(4'h4, 8'h20);
    `TB_CHK(modulated_output_pin, 1'b1)
    wt(40);
    `TB_CHK(modulated_output_pin, 1'b0)
    wr(4'h1, 8'h00);
    wt(10);
    `TB_CHK(modulated_output_pin, 1'b0)
    chk_rd(4'h4, 8'h40);
    wr(4'h1, 8'h00);
    wt(2);
    `TB_CHK(modulated_output_pin, 1'b1)
    wr(4'h1, 8'h80);
    wt(3);
    `TB_CHK(modulated_output_pin, 1'b0)
    // extra pwm sources counted over a 64-cycle run window
    wr(4'h0, 8'h53);
    rd(4'h6);
    n = d;
    wr(4'h1, 8'h08);
    wt(62);
    wr(4'h1, 8'h00);
    chk_rd(4'h6, n[7:0] + 8'h20);
    wr(4'h0, 8'h43);
    rd(4'h6);
    n = d;
    wr(4'h1, 8'h08);
    wt(62);
    wr(4'h1, 8'h00);
    chk_rd(4'h6, n[7:0] + 8'h10);
    stop_test();
  end
endmodule

bind ctp_timer ctp_timer_chk chk_u (.mclk(mclk), .reset_n(reset_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .match_interrupt(match_interrupt),
  .modulated_output_pin(modulated_output_pin));
